// ==== rtl/assd_top.v ====
// Audio serial slot data path: FIFOs, DMA holding registers, shift registers.
// Assumes a single-cycle register port master and pins asynchronous to clk.
//
// Operation
// - Normal mode: each frame sync starts one frame of one slot; all FIFO entries serve it.
// - Eight-bit words keep valid data only in the low byte of each entry.
// - When enabled, each frame sync starts transmit, shifting out on bit clock rising edges.
// - Normal DMA: reload from hold zero, request while empty, resend previous if empty.
// - FIFO transmit: load entry at read pointer after each word, then advance it.
// - Bus write to transmit FIFO port stores at write pointer, then advances it.
// - Equal pointers: empty after last transfer out, full after last bus write.
// - Underrun: read pointer back one, resend previous word, set underrun flag.
// - Clocks and frame syncs are generated internally or supplied by the partner.
// - Receive samples on falling bit clock after frame sync; sync mode uses transmit ones.
// - Normal DMA: completed word to receive hold zero, request while full, overwrite.
// - FIFO receive: completed word stored at write pointer, then pointer advances.
// - Bus read of receive FIFO port returns entry at read pointer, then advances.
// - Word completing into full receive FIFO is discarded and sets the overrun flag.
// - Network mode: frame of up to four slots, taking part only in assigned slots.
// - Network mode: transmit pin driven only in assigned slots, released otherwise.
// - Network DMA: slot word from its hold register, request while empty, resend.
// - Network FIFO: consecutive assigned slots use consecutive FIFO entries.
// - Receive captures every slot; only assigned slots are moved and requested.
// - Network DMA: slot word to its receive hold, request while full, overwrite.
// - Per-slot select bit: zero uses the FIFO, one uses the slot hold register.
// - Sync mode receiver uses transmit bit clock and frame sync.
`timescale 1ns/10ps
`default_nettype none
`include "assd_defines.vh"

module assd_top (
  input  wire        clk,
  input  wire        srst,
  input  wire [7:0]  bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  input  wire        tx_bit_clock_pin_in,
  output reg         tx_bit_clock_pin_out,
  output reg         tx_bit_clock_pin_oe_n,
  input  wire        tx_frame_sync_pin_in,
  output reg         tx_frame_sync_pin_out,
  output reg         tx_frame_sync_pin_oe_n,
  input  wire        rx_bit_clock_pin_in,
  output reg         rx_bit_clock_pin_out,
  output reg         rx_bit_clock_pin_oe_n,
  input  wire        rx_frame_sync_pin_in,
  output reg         rx_frame_sync_pin_out,
  output reg         rx_frame_sync_pin_oe_n,
  input  wire        serial_rx_data_pin,
  output reg         serial_tx_data_pin_out,
  output reg         serial_tx_data_pin_oe_n,
  output reg  [3:0]  tx_dma_req,
  output reg  [3:0]  rx_dma_req
);

  // ==========================================================
  // Functions
  function [3:0] assd_inc;
    input [3:0] p;
    begin
      assd_inc = p + 4'h1;
    end
  endfunction

  // Hold register decode: bit 2 hit, bits 1:0 slot
  function [2:0] assd_hold_dec;
    input [7:0] a;
    input [7:0] base;
    reg   [7:0] off;
    begin
      off = a - base;
      assd_hold_dec = {(off[7:3] == 5'h00) && !off[0] && (off[2:1] != 2'h3 || off[2:0] == 3'h6),
                       off[2:1]};
    end
  endfunction

  function [15:0] assd_mask;
    input [15:0] w;
    input        w16;
    begin
      assd_mask = w16 ? w : {8'h00, w[7:0]};
    end
  endfunction

  // ==========================================================
  // Configuration and state
  reg  [15:0] gcfg;
  reg  [15:0] ccfg;
  reg  [15:0] dcfg;
  reg  [15:0] tx_mem [0:15];
  reg  [15:0] rx_mem [0:15];
  reg  [3:0]  tx_read_ptr;
  reg  [3:0]  tx_write_ptr;
  reg         tx_last_wr;
  reg  [3:0]  rx_read_ptr;
  reg  [3:0]  rx_write_ptr;
  reg         rx_last_wr;
  reg         tx_underrun_flag;
  reg         rx_overrun_flag;
  reg  [15:0] tx_slot_dma_hold [0:3];
  reg  [15:0] rx_slot_dma_hold [0:3];
  reg  [3:0]  tx_hold_full;
  reg  [3:0]  rx_hold_full;
  reg  [15:0] tx_shift_reg;
  reg  [15:0] rx_shift_reg;
  reg  [3:0]  tx_bit;
  reg  [1:0]  tx_slot;
  reg         tx_act;
  reg         tx_drive;
  reg         tx_pend;
  reg  [3:0]  rx_bit;
  reg  [1:0]  rx_slot;
  reg         rx_act;
  reg         rx_pend;
  reg  [7:0]  div_cnt;
  reg         int_sck;
  reg         int_rise;
  reg         int_fall;
  reg  [6:0]  frame_cnt;
  reg         int_fs;
  reg         int_fs_rise;

  wire        en      = gcfg[`ASSD_GC_EN];
  wire        net     = gcfg[`ASSD_GC_NET];
  wire        w16     = gcfg[`ASSD_GC_W16];
  wire        syncm   = gcfg[`ASSD_GC_SYNC];
  wire        tx_int  = gcfg[`ASSD_GC_TXINT];
  wire        rx_int  = gcfg[`ASSD_GC_RXINT];
  wire [1:0]  nlast   = net ? gcfg[`ASSD_GC_SLOTS_HI:`ASSD_GC_SLOTS_LO] : 2'h0;
  wire [3:0]  wlast   = w16 ? `ASSD_WLAST16 : `ASSD_WLAST8;
  wire [3:0]  tx_sa   = dcfg[`ASSD_DC_TXSA_HI:`ASSD_DC_TXSA_LO];
  wire [3:0]  rx_sa   = dcfg[`ASSD_DC_RXSA_HI:`ASSD_DC_RXSA_LO];
  wire [3:0]  tx_ds   = dcfg[`ASSD_DC_TXDS_HI:`ASSD_DC_TXDS_LO];
  wire [3:0]  rx_ds   = dcfg[`ASSD_DC_RXDS_HI:`ASSD_DC_RXDS_LO];
  wire        tx_empty = (tx_read_ptr == tx_write_ptr) && !tx_last_wr;
  wire        tx_full  = (tx_read_ptr == tx_write_ptr) && tx_last_wr;
  wire        rx_empty = (rx_read_ptr == rx_write_ptr) && !rx_last_wr;
  wire        rx_full  = (rx_read_ptr == rx_write_ptr) && rx_last_wr;
  wire [2:0]  txh_dec  = assd_hold_dec(bus_addr, `ASSD_A_TXH_BASE);
  wire [2:0]  rxh_dec  = assd_hold_dec(bus_addr, `ASSD_A_RXH_BASE);

  // ==========================================================
  // Pin synchronisers
  wire [4:0]  s_q;
  wire [4:0]  s_rise;
  wire [4:0]  s_fall;

  assd_sync #(.W(5)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({serial_rx_data_pin, rx_frame_sync_pin_in, rx_bit_clock_pin_in,
            tx_frame_sync_pin_in, tx_bit_clock_pin_in}),
    .q    (s_q),
    .rise (s_rise),
    .fall (s_fall)
  );

  wire tx_rise  = tx_int ? int_rise : s_rise[0];
  wire tx_fall  = tx_int ? int_fall : s_fall[0];
  wire tx_fsr   = tx_int ? int_fs_rise : s_rise[1];
  wire rx_rise  = syncm ? tx_rise : (rx_int ? int_rise : s_rise[2]);
  wire rx_fall  = syncm ? tx_fall : (rx_int ? int_fall : s_fall[2]);
  wire rx_fsr   = syncm ? tx_fsr : (rx_int ? int_fs_rise : s_rise[3]);

  // ==========================================================
  // Internal bit clock and frame sync
  always @(posedge clk) begin
    if (srst) begin
      div_cnt     <= 8'h00;
      int_sck     <= 1'b0;
      int_rise    <= 1'b0;
      int_fall    <= 1'b0;
      frame_cnt   <= 7'h00;
      int_fs      <= 1'b0;
      int_fs_rise <= 1'b0;
    end else begin
      int_rise    <= 1'b0;
      int_fall    <= 1'b0;
      int_fs_rise <= 1'b0;
      if (!en) begin
        div_cnt   <= 8'h00;
        int_sck   <= 1'b0;
        frame_cnt <= 7'h00;
        int_fs    <= 1'b0;
      end else if (div_cnt == ccfg[`ASSD_CC_DIV_HI:`ASSD_CC_DIV_LO]) begin
        div_cnt <= 8'h00;
        int_sck <= ~int_sck;
        if (!int_sck) begin
          int_rise <= 1'b1;
          if (frame_cnt == ccfg[`ASSD_CC_FLEN_HI:`ASSD_CC_FLEN_LO]) begin
            frame_cnt   <= 7'h00;
            int_fs      <= 1'b1;
            int_fs_rise <= ~int_fs;
          end else begin
            frame_cnt <= frame_cnt + 7'h01;
            int_fs    <= 1'b0;
          end
        end else begin
          int_fall <= 1'b1;
        end
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // ==========================================================
  // Transmit load decision
  wire        tx_start = en && tx_rise && tx_pend;
  wire        tx_next  = en && tx_rise && !tx_pend && tx_act && tx_bit == wlast
                         && tx_slot != nlast;
  wire        tx_ld    = tx_start || tx_next;
  wire [1:0]  ld_slot  = tx_start ? 2'h0 : tx_slot + 2'h1;
  // slot assignment, normal mode only slot zero
  wire        tx_asg   = net ? tx_sa[ld_slot] : 1'b1;
  wire        tx_dsel  = net ? tx_ds[ld_slot] : tx_ds[0];
  wire        tx_frd   = tx_ld && tx_asg && !tx_dsel;
  wire        tx_drd   = tx_ld && tx_asg && tx_dsel;
  wire        tx_fwr   = bus_wr && bus_addr == `ASSD_A_TXF;
  wire [15:0] tx_fword = tx_empty ? tx_mem[tx_read_ptr - 4'h1] : tx_mem[tx_read_ptr];
  // hold keeps previous word while empty
  wire [15:0] tx_word  = tx_dsel ? tx_slot_dma_hold[ld_slot] : tx_fword;
  wire        tx_ufl   = tx_frd && tx_empty;

  // ==========================================================
  // Transmit shifter
  always @(posedge clk) begin
    if (srst) begin
      tx_shift_reg <= 16'h0000;
      tx_bit       <= 4'h0;
      tx_slot      <= 2'h0;
      tx_act       <= 1'b0;
      tx_drive     <= 1'b0;
      tx_pend      <= 1'b0;
    end else begin
      tx_pend <= en && (tx_fsr || (tx_pend && !tx_rise));
      if (!en) begin
        tx_act   <= 1'b0;
        tx_drive <= 1'b0;
      end else if (tx_ld) begin
        // word starts at a rising edge after frame sync, or at the rising edge ending the previous slot's last bit
        tx_shift_reg <= assd_mask(tx_word, w16);
        tx_bit       <= 4'h0;
        tx_slot      <= ld_slot;
        tx_act       <= 1'b1;
        tx_drive     <= tx_asg;
      end else if (tx_rise && tx_act) begin
        if (tx_bit == wlast) begin
          tx_act   <= 1'b0;
          tx_drive <= 1'b0;
        end else begin
          tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
          tx_bit       <= tx_bit + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Transmit FIFO and holds
  always @(posedge clk) begin
    if (tx_fwr) begin
      tx_mem[tx_write_ptr] <= bus_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      tx_read_ptr      <= 4'h0;
      tx_write_ptr     <= 4'h0;
      tx_last_wr       <= 1'b0;
      tx_underrun_flag <= 1'b0;
      tx_hold_full     <= 4'h0;
    end else begin
      // advance write pointer, wraps at sixteen
      if (tx_fwr) begin
        tx_write_ptr <= assd_inc(tx_write_ptr);
      end
      // step back on underrun, advance after load, next entry
      if (tx_ufl) begin
        tx_read_ptr <= tx_read_ptr + 4'hF;
      end else if (tx_frd) begin
        tx_read_ptr <= assd_inc(tx_read_ptr);
      end
      if (tx_fwr && !tx_frd) begin
        tx_last_wr <= 1'b1;
      end else if (tx_frd && !tx_fwr) begin
        tx_last_wr <= 1'b0;
      end
      // sticky underrun, set wins over clear
      tx_underrun_flag <= tx_ufl || (tx_underrun_flag
                          && !(bus_wr && bus_addr == `ASSD_A_TXSTAT && bus_wdata[`ASSD_ST_ERR]));
      // hold empty after load, full after bus write
      tx_hold_full <= (tx_hold_full & ~({3'h0, tx_drd} << ld_slot))
                      | ({3'h0, bus_wr && txh_dec[2]} << txh_dec[1:0]);
    end
  end

  always @(posedge clk) begin
    if (bus_wr && txh_dec[2]) begin
      tx_slot_dma_hold[txh_dec[1:0]] <= bus_wdata;
    end
  end

  // ==========================================================
  // Receive shifter
  wire [15:0] rx_word = assd_mask({rx_shift_reg[14:0], s_q[4]}, w16);
  wire        rx_done = en && rx_fall && rx_act && rx_bit == wlast;
  wire        rx_asg  = net ? rx_sa[rx_slot] : 1'b1;
  wire        rx_dsel = net ? rx_ds[rx_slot] : rx_ds[0];
  wire        rx_fwr  = rx_done && rx_asg && !rx_dsel;
  wire        rx_dwr  = rx_done && rx_asg && rx_dsel;
  wire        rx_frd  = bus_rd && bus_addr == `ASSD_A_RXF;
  wire        rx_ofl  = rx_fwr && rx_full;

  always @(posedge clk) begin
    if (srst) begin
      rx_shift_reg <= 16'h0000;
      rx_bit       <= 4'h0;
      rx_slot      <= 2'h0;
      rx_act       <= 1'b0;
      rx_pend      <= 1'b0;
    end else begin
      rx_pend <= en && (rx_fsr || (rx_pend && !rx_rise));
      if (!en) begin
        rx_act <= 1'b0;
      end else if (rx_rise && rx_pend) begin
        rx_bit  <= 4'h0;
        rx_slot <= 2'h0;
        rx_act  <= 1'b1;
      end else if (rx_fall && rx_act) begin
        // sample on falling edge, every slot captured
        rx_shift_reg <= {rx_shift_reg[14:0], s_q[4]};
        if (rx_bit == wlast) begin
          rx_bit  <= 4'h0;
          rx_slot <= rx_slot + 2'h1;
          rx_act  <= rx_slot != nlast;
        end else begin
          rx_bit <= rx_bit + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Receive FIFO and holds
  always @(posedge clk) begin
    if (rx_fwr && !rx_full) begin
      // store at write pointer, low byte only in 8-bit mode
      rx_mem[rx_write_ptr] <= rx_word;
    end
  end

  always @(posedge clk) begin
    if (rx_dwr) begin
      rx_slot_dma_hold[rx_slot] <= rx_word;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rx_read_ptr     <= 4'h0;
      rx_write_ptr    <= 4'h0;
      rx_last_wr      <= 1'b0;
      rx_overrun_flag <= 1'b0;
      rx_hold_full    <= 4'h0;
    end else begin
      // pointer kept on overrun, next entry per slot
      if (rx_fwr && !rx_full) begin
        rx_write_ptr <= assd_inc(rx_write_ptr);
      end
      if (rx_frd) begin
        rx_read_ptr <= assd_inc(rx_read_ptr);
      end
      if (rx_fwr && !rx_full && !rx_frd) begin
        rx_last_wr <= 1'b1;
      end else if (rx_frd && !(rx_fwr && !rx_full)) begin
        rx_last_wr <= 1'b0;
      end
      // sticky overrun, set wins over clear
      rx_overrun_flag <= rx_ofl || (rx_overrun_flag
                         && !(bus_wr && bus_addr == `ASSD_A_RXSTAT && bus_wdata[`ASSD_ST_ERR]));
      // full on word, empty on bus read, set wins
      rx_hold_full <= (rx_hold_full & ~({3'h0, bus_rd && rxh_dec[2]} << rxh_dec[1:0]))
                      | ({3'h0, rx_dwr} << rx_slot);
    end
  end

  // ==========================================================
  // Register port
  always @(posedge clk) begin
    if (srst) begin
      gcfg      <= `ASSD_GCFG_RST;
      ccfg      <= `ASSD_CCFG_RST;
      dcfg      <= `ASSD_DCFG_RST;
      bus_rdata <= 16'h0000;
    end else begin
      if (bus_wr && bus_addr == `ASSD_A_GCFG) begin
        gcfg <= bus_wdata;
      end
      if (bus_wr && bus_addr == `ASSD_A_CCFG) begin
        ccfg <= bus_wdata;
      end
      if (bus_wr && bus_addr == `ASSD_A_DCFG) begin
        dcfg <= bus_wdata;
      end
      if (bus_rd) begin
        if (rx_frd) begin
          bus_rdata <= rx_mem[rx_read_ptr];
        end else if (rxh_dec[2]) begin
          bus_rdata <= rx_slot_dma_hold[rxh_dec[1:0]];
        end else if (txh_dec[2]) begin
          bus_rdata <= tx_slot_dma_hold[txh_dec[1:0]];
        end else if (bus_addr == `ASSD_A_GCFG) begin
          bus_rdata <= gcfg;
        end else if (bus_addr == `ASSD_A_CCFG) begin
          bus_rdata <= ccfg;
        end else if (bus_addr == `ASSD_A_DCFG) begin
          bus_rdata <= dcfg;
        end else if (bus_addr == `ASSD_A_TXSTAT) begin
          bus_rdata <= {tx_write_ptr, tx_read_ptr, 5'h00, tx_full, tx_empty, tx_underrun_flag};
        end else if (bus_addr == `ASSD_A_RXSTAT) begin
          bus_rdata <= {rx_write_ptr, rx_read_ptr, 5'h00, rx_full, rx_empty, rx_overrun_flag};
        end else begin
          bus_rdata <= 16'h0000;
        end
      end else begin
        bus_rdata <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Pin and request outputs
  always @(posedge clk) begin
    if (srst) begin
      tx_bit_clock_pin_out    <= 1'b0;
      tx_bit_clock_pin_oe_n   <= 1'b1;
      tx_frame_sync_pin_out   <= 1'b0;
      tx_frame_sync_pin_oe_n  <= 1'b1;
      rx_bit_clock_pin_out    <= 1'b0;
      rx_bit_clock_pin_oe_n   <= 1'b1;
      rx_frame_sync_pin_out   <= 1'b0;
      rx_frame_sync_pin_oe_n  <= 1'b1;
      serial_tx_data_pin_out  <= 1'b0;
      serial_tx_data_pin_oe_n <= 1'b1;
      tx_dma_req              <= 4'h0;
      rx_dma_req              <= 4'h0;
    end else begin
      tx_bit_clock_pin_out    <= int_sck;
      tx_bit_clock_pin_oe_n   <= !(en && tx_int);
      tx_frame_sync_pin_out   <= int_fs;
      tx_frame_sync_pin_oe_n  <= !(en && tx_int);
      rx_bit_clock_pin_out    <= int_sck;
      rx_bit_clock_pin_oe_n   <= !(en && rx_int && !syncm);
      rx_frame_sync_pin_out   <= int_fs;
      rx_frame_sync_pin_oe_n  <= !(en && rx_int && !syncm);
      serial_tx_data_pin_out  <= w16 ? tx_shift_reg[15] : tx_shift_reg[7];
      serial_tx_data_pin_oe_n <= !(tx_act && tx_drive);
      // request while hold empty, while hold full
      tx_dma_req <= {4{en}} & tx_ds & (net ? 4'hF : 4'h1) & ~tx_hold_full;
      rx_dma_req <= {4{en}} & rx_ds & (net ? 4'hF : 4'h1) & rx_hold_full;
    end
  end

endmodule

`default_nettype wire

// ==== pkg/assd_defines.vh ====
// Constants of the audio serial slot data path: register offsets,
// field positions, reset values and word-length counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ASSD_DEFINES_VH
`define ASSD_DEFINES_VH

// ==========================================================
// Register offsets
`define ASSD_A_RXF       8'h40
`define ASSD_A_RXH_BASE  8'h42
`define ASSD_A_TXF       8'h4A
`define ASSD_A_TXH_BASE  8'h4C
`define ASSD_A_GCFG      8'h54
`define ASSD_A_RXSTAT    8'h58
`define ASSD_A_TXSTAT    8'h5A
`define ASSD_A_CCFG      8'h5C
`define ASSD_A_DCFG      8'h5E

// ==========================================================
// Global configuration fields
`define ASSD_GC_EN        0
`define ASSD_GC_NET       1
`define ASSD_GC_W16       2
`define ASSD_GC_SYNC      3
`define ASSD_GC_TXINT     4
`define ASSD_GC_RXINT     5
`define ASSD_GC_SLOTS_LO  8
`define ASSD_GC_SLOTS_HI  9

// ==========================================================
// Clock configuration fields
`define ASSD_CC_DIV_LO    0
`define ASSD_CC_DIV_HI    7
`define ASSD_CC_FLEN_LO   8
`define ASSD_CC_FLEN_HI   14

// ==========================================================
// Slot assignment and path select fields
`define ASSD_DC_TXSA_LO   0
`define ASSD_DC_TXSA_HI   3
`define ASSD_DC_RXSA_LO   4
`define ASSD_DC_RXSA_HI   7
`define ASSD_DC_TXDS_LO   8
`define ASSD_DC_TXDS_HI   11
`define ASSD_DC_RXDS_LO   12
`define ASSD_DC_RXDS_HI   15

// ==========================================================
// Status fields
`define ASSD_ST_ERR       0
`define ASSD_ST_EMPTY     1
`define ASSD_ST_FULL      2

// ==========================================================
// Reset values and counts
`define ASSD_GCFG_RST     16'h0000
`define ASSD_CCFG_RST     16'h0F03
`define ASSD_DCFG_RST     16'h0011
`define ASSD_WLAST16      4'hF
`define ASSD_WLAST8       4'h7

`endif

// ==== rtl/assd_sync.v ====
// Two-stage synchroniser with edge detection for pin inputs.
// Assumes inputs are asynchronous to clk; outputs are on clk.
`timescale 1ns/10ps
`default_nettype none

module assd_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] meta;
  reg [W-1:0] stab;
  reg [W-1:0] prev;

  // ==========================================================
  // Synchroniser chain
  always @(posedge clk) begin
    if (srst) begin
      meta <= {W{1'b0}};
      stab <= {W{1'b0}};
      prev <= {W{1'b0}};
    end else begin
      meta <= d;
      stab <= meta;
      prev <= stab;
    end
  end

  assign q    = stab;
  assign rise = stab & ~prev;
  assign fall = ~stab & prev;

endmodule

`default_nettype wire

// ==== test/assd_chk_asserts.sv ====
// Port checker of the slot data path.
// Assumes binding into assd_top by port name.
`timescale 1ns/10ps
`default_nettype none
module assd_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic        tx_bit_clock_pin_in,
  input wire logic        tx_bit_clock_pin_oe_n,
  input wire logic        tx_frame_sync_pin_oe_n,
  input wire logic        rx_bit_clock_pin_oe_n,
  input wire logic        rx_frame_sync_pin_oe_n,
  input wire logic        serial_tx_data_pin_out,
  input wire logic        serial_tx_data_pin_oe_n,
  input wire logic [3:0]  tx_dma_req,
  input wire logic [3:0]  rx_dma_req
);
  // ==========
  // Config shadow
  logic [15:0] gc;
  logic [15:0] dc;
  always_ff @(posedge clk) begin
    if (srst) begin
      gc <= 16'h0000;
      dc <= 16'h0011;
    end else if (bus_wr) begin
      if (bus_addr == 8'h54) gc <= bus_wdata;
      if (bus_addr == 8'h5E) dc <= bus_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========
  // Properties
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_tx_on_rise: assert property (!serial_tx_data_pin_oe_n && $changed(serial_tx_data_pin_out)
    |-> $past(tx_bit_clock_pin_in)) else $error("tx bit moved off rising edge");
  a_normal_slot: assert property (!gc[1] && !$past(gc[1]) |->
    tx_dma_req[3:1] == 3'h0 && rx_dma_req[3:1] == 3'h0) else $error("slot request in normal");
  a_idle_quiet: assert property (!gc[0] && !$past(gc[0]) |->
    tx_dma_req == 4'h0 && serial_tx_data_pin_oe_n) else $error("activity while disabled");
  a_txreq_clear: assert property (serial_tx_data_pin_oe_n && bus_wr && bus_addr == 8'h4C
    ##1 serial_tx_data_pin_oe_n |=> !tx_dma_req[0]) else $error("tx request after fill");
  a_net_release: assert property (gc[1] && dc[3:0] == 4'h0 && $past(dc[3:0] == 4'h0)
    |-> serial_tx_data_pin_oe_n) else $error("tx pin driven unassigned");
  a_sync_release: assert property (gc[3] && $past(gc[3]) |->
    rx_bit_clock_pin_oe_n && rx_frame_sync_pin_oe_n) else $error("rx pins driven in sync");
  a_clk_released: assert property (!(gc[0] && gc[4]) && $past(!(gc[0] && gc[4])) |->
    tx_bit_clock_pin_oe_n && tx_frame_sync_pin_oe_n) else $error("tx clock driven");
endmodule
bind assd_top assd_chk u_assd_chk (.*);
`default_nettype wire

// ==== test/assd_codec.sv ====
// Codec model: makes bit clock, short sync and rx data, captures tx bits.
// Assumes the bench resolves the tx data line.
`timescale 1ns/10ps
`default_nettype none
module assd_codec (
  input wire logic    tx_line,
  output logic        bck,
  output logic        fs,
  output logic        sd,
  output logic [15:0] cap
);
  initial begin
    bck = 1'b0;
    fs = 1'b0;
    sd = 1'b0;
    cap = 16'h0000;
  end
  task automatic frame(input logic [15:0] w, input int n);
    cap = 16'h0000;
    for (int i = 0; i <= n + 1; i++) begin
      bck = 1'b1;
      fs = (i == 0);
      sd = (i >= 1 && i <= n) ? w[(n - i) % 16] : ~sd;
      #80;
      bck = 1'b0;
      if (i >= 1 && i <= n) cap = {cap[14:0], tx_line};
      #80;
    end
  endtask
endmodule
`default_nettype wire

// ==== test/tb_audio_serial_slot_datapath.sv ====
// Bench: bus tasks, codec frames, read data watcher.
// Assumes assd_codec and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_audio_serial_slot_datapath;
  logic        clk, srst, bus_wr, bus_rd, rd_d;
  logic [7:0]  bus_addr;
  logic [15:0] bus_wdata, h;
  logic [31:0] seed;
  logic [15:0] w [16];
  logic [15:0] r [17];
  logic [7:0]  qa [$];
  logic [15:0] qe [$];
  int          mismatches, compares;
  wire logic [15:0] bus_rdata, cap;
  wire logic [3:0]  tx_dma_req, rx_dma_req;
  wire logic tbo, tbe, tfo, tfe, rbo, rbe, rfo, rfe, sdo, sde, bck, fs, sd;
  assd_top u_assd_top (.clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .tx_bit_clock_pin_in(tbe ? bck : tbo), .tx_bit_clock_pin_out(tbo),
    .tx_bit_clock_pin_oe_n(tbe), .tx_frame_sync_pin_in(tfe ? fs : tfo),
    .tx_frame_sync_pin_out(tfo), .tx_frame_sync_pin_oe_n(tfe),
    .rx_bit_clock_pin_in(rbe ? bck : rbo), .rx_bit_clock_pin_out(rbo),
    .rx_bit_clock_pin_oe_n(rbe), .rx_frame_sync_pin_in(rfe ? fs : rfo),
    .rx_frame_sync_pin_out(rfo), .rx_frame_sync_pin_oe_n(rfe), .serial_rx_data_pin(sd),
    .serial_tx_data_pin_out(sdo), .serial_tx_data_pin_oe_n(sde), .tx_dma_req, .rx_dma_req);
  assd_codec u_assd_codec (.tx_line(sde ? 1'bz : sdo), .bck, .fs, .sd, .cap);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    qa.push_back(a);
    qe.push_back(e);
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask
  task automatic req_chk(input logic [3:0] t, input logic [3:0] x);
    repeat (2) @(posedge clk);
    #1;
    chk("tx req", {12'h000, tx_dma_req}, {12'h000, t});
    chk("rx req", {12'h000, rx_dma_req}, {12'h000, x});
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // Read data watcher
  always @(posedge clk) begin
    rd_d <= bus_rd;
    if (rd_d) chk($sformatf("reg %h", qa.pop_front()), bus_rdata, qe.pop_front());
  end
  initial begin
    #200000;
    mismatches++;
    results;
  end
  // ==========
  // Main sequence
  initial begin
    {srst, bus_wr, bus_rd, bus_addr, bus_wdata} = {3'h4, 24'h000000};
    seed = 32'hB20B1B2E;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(8'h5A, 16'h0002);
    rd(8'h58, 16'h0002);
    rd(8'h00, 16'h0000);
    wr(8'h54, 16'h0005);
    for (int i = 0; i < 16; i++) begin
      w[i] = rnd();
      wr(8'h4A, w[i]);
    end
    rd(8'h5A, 16'h0004);
    for (int i = 0; i < 17; i++) begin
      r[i] = rnd();
      @(negedge clk);
      u_assd_codec.frame(r[i], 16);
      chk("tx word", cap, w[i > 15 ? 15 : i]);
    end
    rd(8'h5A, 16'h0F01);
    rd(8'h58, 16'h0005);
    wr(8'h5A, 16'h0001);
    wr(8'h58, 16'h0001);
    for (int i = 0; i < 16; i++) rd(8'h40, r[i]);
    rd(8'h58, 16'h0002);
    rd(8'h5A, 16'h0F00);
    wr(8'h54, 16'h0001);
    h = rnd();
    @(negedge clk);
    u_assd_codec.frame(h, 8);
    chk("tx byte", cap, {8'h00, w[15][7:0]});
    rd(8'h40, {8'h00, h[7:0]});
    wr(8'h54, 16'h0005);
    wr(8'h5E, 16'h1111);
    req_chk(4'h1, 4'h0);
    h = rnd();
    wr(8'h4C, h);
    req_chk(4'h0, 4'h0);
    for (int i = 0; i < 2; i++) begin
      r[i] = rnd();
      @(negedge clk);
      u_assd_codec.frame(r[i], 16);
      chk("tx hold", cap, h);
      req_chk(4'h1, 4'h1);
    end
    rd(8'h42, r[1]);
    req_chk(4'h1, 4'h0);
    wr(8'h5E, 16'h0022);
    wr(8'h54, 16'h0107);
    h = rnd();
    r[0] = rnd();
    wr(8'h4A, h);
    @(negedge clk);
    u_assd_codec.frame(r[0], 32);
    chk("net slot", cap, h);
    rd(8'h40, r[0]);
    wr(8'h5E, 16'h0000);
    wr(8'h54, 16'h001F);
    req_chk(4'h0, 4'h0);
    h = {15'h0000, tbo};
    repeat (4) @(posedge clk);
    #1;
    chk("bit clock", {15'h0000, tbo}, {15'h0000, ~h[0]});
    chk("pin oe", {12'h000, tbe, tfe, rbe, rfe}, 16'h0003);
    results;
  end
endmodule
`default_nettype wire
